// file: pkg/sensor_map_defines.svh
/*
 Constants of the command/status register and of the result memory map.
 Assumes inclusion by bare name from the package and from both ends.
*/
`ifndef SENSOR_MAP_DEFINES_SVH
`define SENSOR_MAP_DEFINES_SVH

`define CMD_ADDR 32'h2900_0000
`define MAP_BASE 32'h2900_0000
`define XZERO_ADDR 32'h2900_0004
`define YZERO_ADDR 32'h2900_0008
`define BATT_ADDR 32'h2900_000C
`define XSET_ADDR 32'h2900_0012
`define YSET_ADDR 32'h2900_001A
`define XRST_ADDR 32'h2900_0022
`define YRST_ADDR 32'h2900_002A
`define TEMP_ADDR 32'h2900_0032
`define PRES_ADDR 32'h2900_0042
`define HALF_STEP 32'h0000_0002
`define SAMPLE_COUNT 2'h3
`define EXEC_BIT 5
`define DONE_BIT 4
`define BATT_BIT 2
`define PRES_HI_BIT 1
`define PRES_LO_BIT 0
`define CMD_RESET 8'h00
`define CMD_WMASK 8'h27
`define RANGE_ZERO 2'h0
`define RANGE_ONE 2'h1
`define RANGE_TWO 2'h2
`define RANGE_THREE 2'h3

`endif

// file: pkg/sensor_map_pkg.sv
/*
 Types shared by both ends of the command/status link.
 Assumes sensor_map_defines.svh is on the include path.
*/
package sensor_map_pkg;
    `include "sensor_map_defines.svh"

    typedef enum logic [3:0] {
        ST_XZERO, ST_YZERO, ST_BATT, ST_XSET, ST_YSET, ST_XRST, ST_YRST, ST_TEMP, ST_PRES
    } slot_e;
endpackage

// file: pkg/sensor_map_if.sv
/*
 Host bus plus shared SRAM bus between the host and the acquisition module.
 Assumes the testbench resolves SRAM data from the two enables.
*/
`timescale 1ns/100ps
interface sensor_map_if;
    // Host bus
    logic [31:0] hostAddr;
    logic hostWrite;
    logic hostRead;
    logic [15:0] hostWdata;
    logic [15:0] hostRdata;
    logic hostRvalid;
    // Shared SRAM bus, device side
    logic [31:0] devSramAddr;
    logic [15:0] devSramWdata;
    logic devSramWe;
    logic devSramOe;
    logic devOwnsSram;

    modport device (
        input hostAddr, hostWrite, hostRead, hostWdata,
        output hostRdata, hostRvalid, devSramAddr, devSramWdata, devSramWe, devSramOe, devOwnsSram
    );
    modport host (
        output hostAddr, hostWrite, hostRead, hostWdata,
        input hostRdata, hostRvalid, devOwnsSram
    );
endinterface

// file: src/sensor_host_end.sv
/*
 Host end: writes commands, polls the completion flag, reads results.
 Assumes a device end on the same sensor_map_if.
*/
`timescale 1ns/100ps
`include "sensor_map_defines.svh"
module sensor_host_end
    import sensor_map_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // User side
    input wire logic startReq,
    input wire logic batteryOn,
    input wire logic [1:0] rangeSel,
    input wire logic [31:0] readAddr,
    input wire logic readReq,
    output logic busy,
    output logic [15:0] readData_r,
    output logic readValid_r,
    // Link
    sensor_map_if.host link
);
    typedef enum logic [2:0] {H_IDLE, H_POLL, H_WAIT, H_READ, H_RWAIT} hstate_e;
    hstate_e state_r, state_nxt;
    logic [15:0] readData_nxt;
    logic readValid_nxt;

    always_comb begin
        state_nxt = state_r;
        readData_nxt = readData_r;
        readValid_nxt = 1'b0;
        link.hostAddr = `CMD_ADDR;
        link.hostWrite = 1'b0;
        link.hostRead = 1'b0;
        link.hostWdata = 16'h0000;
        unique case (state_r)
            H_IDLE: begin
                if (startReq) begin
                    // Battery must be on with an execute request
                    link.hostWrite = 1'b1;
                    link.hostWdata[`EXEC_BIT] = 1'b1;
                    link.hostWdata[`BATT_BIT] = 1'b1;
                    link.hostWdata[`PRES_HI_BIT:`PRES_LO_BIT] = rangeSel;
                    state_nxt = H_POLL;
                end else if (readReq) begin
                    state_nxt = H_READ;
                end else begin
                    link.hostWrite = 1'b1;
                    link.hostWdata[`BATT_BIT] = batteryOn;
                    link.hostWdata[`PRES_HI_BIT:`PRES_LO_BIT] = rangeSel;
                end
            end
            H_POLL: begin
                link.hostRead = 1'b1;
                state_nxt = H_WAIT;
            end
            H_WAIT: begin
                if (link.hostRvalid) begin
                    state_nxt = link.hostRdata[`DONE_BIT] ? H_IDLE : H_POLL;
                end
            end
            H_READ: begin
                // Only reached from idle, so completion was already seen
                link.hostAddr = readAddr;
                link.hostRead = 1'b1;
                state_nxt = H_RWAIT;
            end
            H_RWAIT: begin
                link.hostAddr = readAddr;
                if (link.hostRvalid) begin
                    readData_nxt = link.hostRdata;
                    readValid_nxt = 1'b1;
                    state_nxt = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= H_IDLE;
            readData_r <= 16'h0000;
            readValid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            readData_r <= readData_nxt;
            readValid_r <= readValid_nxt;
        end
    end

    assign busy = (state_r != H_IDLE);
endmodule // sensor_host_end

// file: src/sensor_device_end.sv
/*
 Device end: command/status register, range and battery outputs, and the
 writer that stores one acquisition into the shared SRAM.
 Assumes sample data arrive on a valid strobe from converter logic outside.
*/
`timescale 1ns/100ps
`include "sensor_map_defines.svh"
// Operation
// - One command/status register at base address
// - Bit five requests an execute cycle
// - Bit four set when cycle finishes
// - Host polls completion before reading results
// - Device owns SRAM while completion clear
// - Device releases SRAM when completion set
// - Host sets battery bit with execute
// - Battery bit zero turns supply off
// - Host writes two pressure range bits
// - Range codes zero through three by elevation
// - Acquired readings are stored in SRAM
// - Zero values and battery at fixed addresses
// - X set/reset triples at fixed addresses
// - Y set/reset triples at fixed addresses
// - Temperature and pressure triples at fixed addresses
// - One range enable high, none for zero
// - Battery output follows battery bit
module sensor_device_end
    import sensor_map_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Sample source
    input wire logic sampleValid,
    input wire logic [15:0] sampleData,
    output logic acquiring,
    // Analog controls
    output logic batteryEnable,
    output logic pressure_range_one_enable,
    output logic pressure_range_two_enable,
    output logic pressure_range_three_enable,
    // Link
    sensor_map_if.device link
);
    logic execute_request_bit_r, execute_request_bit_nxt;
    logic done_r, done_nxt;
    logic finish_r, finish_nxt;
    logic battery_enable_bit_r, battery_enable_bit_nxt;
    logic [1:0] pressureRange_r, pressureRange_nxt;
    slot_e slot_r, slot_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [31:0] sramAddr_r, sramAddr_nxt;
    logic [15:0] sramData_r, sramData_nxt;
    logic sramWe_r, sramWe_nxt;
    logic [15:0] hostRdata_r, hostRdata_nxt;
    logic hostRvalid_r, hostRvalid_nxt;
    logic cmdHit;
    logic [7:0] cmdView;
    logic [31:0] slotBase;
    logic lastSlot;
    logic cmdWrite;
    logic execAccept;
    logic sampleTake;
    logic lastSample;
    logic [2:0] rangeOneHot;

    assign cmdHit = (link.hostAddr == `CMD_ADDR);
    // Unused bits tie to zero
    assign cmdView = {2'b00, execute_request_bit_r, done_r, 1'b0, battery_enable_bit_r, pressureRange_r};

    always_comb begin
        unique case (slot_r)
            ST_XZERO: slotBase = `XZERO_ADDR;
            ST_YZERO: slotBase = `YZERO_ADDR;
            ST_BATT: slotBase = `BATT_ADDR;
            ST_XSET: slotBase = `XSET_ADDR;
            ST_YSET: slotBase = `YSET_ADDR;
            ST_XRST: slotBase = `XRST_ADDR;
            ST_YRST: slotBase = `YRST_ADDR;
            ST_TEMP: slotBase = `TEMP_ADDR;
            default: slotBase = `PRES_ADDR;
        endcase
    end

    // Single values take one slot, triples take three consecutive halfwords
    assign lastSlot = (slot_r inside {ST_XZERO, ST_YZERO, ST_BATT}) || (idx_r == `SAMPLE_COUNT - 2'h1);

    assign cmdWrite = link.hostWrite && cmdHit;
    // A request during a running cycle is ignored
    assign execAccept = cmdWrite && link.hostWdata[`EXEC_BIT] && !execute_request_bit_r;
    // No further sample is taken while the final write drains
    assign sampleTake = execute_request_bit_r && !finish_r && sampleValid;
    assign lastSample = sampleTake && lastSlot && (slot_r == ST_PRES);

    // Command/status register
    always_comb begin
        execute_request_bit_nxt = execute_request_bit_r;
        done_nxt = done_r;
        finish_nxt = 1'b0;
        battery_enable_bit_nxt = battery_enable_bit_r;
        pressureRange_nxt = pressureRange_r;
        if (cmdWrite) begin
            battery_enable_bit_nxt = link.hostWdata[`BATT_BIT];
            pressureRange_nxt = link.hostWdata[`PRES_HI_BIT:`PRES_LO_BIT];
        end
        if (execAccept) begin
            execute_request_bit_nxt = 1'b1;
            done_nxt = 1'b0;
        end
        // Completion waits one cycle so the last pressure write lands before release
        if (lastSample) begin
            finish_nxt = 1'b1;
        end
        if (finish_r) begin
            execute_request_bit_nxt = 1'b0;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            execute_request_bit_r <= 1'b0;
            // The SRAM belongs to the host after reset
            done_r <= 1'b1;
            finish_r <= 1'b0;
            battery_enable_bit_r <= 1'b0;
            pressureRange_r <= `RANGE_ZERO;
        end else begin
            execute_request_bit_r <= execute_request_bit_nxt;
            done_r <= done_nxt;
            finish_r <= finish_nxt;
            battery_enable_bit_r <= battery_enable_bit_nxt;
            pressureRange_r <= pressureRange_nxt;
        end
    end

    // Result writer
    always_comb begin
        slot_nxt = slot_r;
        idx_nxt = idx_r;
        sramAddr_nxt = sramAddr_r;
        sramData_nxt = sramData_r;
        sramWe_nxt = 1'b0;
        if (execAccept) begin
            slot_nxt = ST_XZERO;
            idx_nxt = 2'h0;
        end
        if (sampleTake) begin
            sramAddr_nxt = slotBase + {29'h0, idx_r, 1'b0};
            sramData_nxt = sampleData;
            sramWe_nxt = 1'b1;
            if (lastSlot) begin
                idx_nxt = 2'h0;
                if (slot_r != ST_PRES) begin
                    slot_nxt = slot_e'(slot_r + 4'h1);
                end
            end else begin
                idx_nxt = idx_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_r <= ST_XZERO;
            idx_r <= 2'h0;
            sramAddr_r <= `MAP_BASE;
            sramData_r <= 16'h0000;
            sramWe_r <= 1'b0;
        end else begin
            slot_r <= slot_nxt;
            idx_r <= idx_nxt;
            sramAddr_r <= sramAddr_nxt;
            sramData_r <= sramData_nxt;
            sramWe_r <= sramWe_nxt;
        end
    end

    // Register read answer
    always_comb begin
        hostRdata_nxt = hostRdata_r;
        hostRvalid_nxt = 1'b0;
        if (link.hostRead && cmdHit) begin
            hostRdata_nxt = {8'h00, cmdView};
            hostRvalid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hostRdata_r <= 16'h0000;
            hostRvalid_r <= 1'b0;
        end else begin
            hostRdata_r <= hostRdata_nxt;
            hostRvalid_r <= hostRvalid_nxt;
        end
    end

    assign link.devOwnsSram = !done_r;
    assign link.devSramAddr = sramAddr_r;
    assign link.devSramWdata = sramData_r;
    assign link.devSramWe = sramWe_r & !done_r;
    assign link.devSramOe = !done_r;
    assign link.hostRdata = hostRdata_r;
    assign link.hostRvalid = hostRvalid_r;
    assign acquiring = execute_request_bit_r;
    assign batteryEnable = battery_enable_bit_r;
    // One enable per nonzero range code; range zero leaves all three low
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_range
            assign rangeOneHot[g] = (pressureRange_r == 2'(g + 1));
        end
    endgenerate
    assign pressure_range_one_enable = rangeOneHot[0];
    assign pressure_range_two_enable = rangeOneHot[1];
    assign pressure_range_three_enable = rangeOneHot[2];
endmodule // sensor_device_end

// file: testbench/sensor_map_chk.sv
/*
 Concurrent checks on the link between host end and device end.
 Assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/100ps
`include "sensor_map_defines.svh"
module sensor_map_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    input wire logic [31:0] hostAddr,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [15:0] hostWdata,
    input wire logic [15:0] hostRdata,
    input wire logic hostRvalid,
    input wire logic [31:0] devSramAddr,
    input wire logic devSramWe,
    input wire logic devSramOe,
    input wire logic devOwnsSram
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_read_answer: assert property (hostRead && hostAddr == `CMD_ADDR |=> hostRvalid)
        else $error("register read got no answer");
    chk_exec_taken: assert property (hostWrite && hostAddr == `CMD_ADDR && hostWdata[`EXEC_BIT] && !devOwnsSram
        |=> devOwnsSram)
        else $error("execute request not taken");
    chk_own_holds: assert property ($rose(devOwnsSram) |-> devOwnsSram[*8])
        else $error("completion returned too early");
    chk_own_drives: assert property (devOwnsSram |-> devSramOe)
        else $error("SRAM not driven while owned");
    chk_bus_released: assert property (!devOwnsSram |-> !devSramOe && !devSramWe)
        else $error("SRAM driven after release");
    chk_write_map: assert property (devSramWe |-> !devSramAddr[0] && devSramAddr >= `XZERO_ADDR
        && devSramAddr <= `PRES_ADDR + 32'h0000_0004)
        else $error("SRAM write outside result map");
    chk_unused_zero: assert property (hostRvalid |-> hostRdata[7:6] == 2'h0 && !hostRdata[3])
        else $error("unused register bit reads one");
    chk_done_mirror: assert property (hostRvalid && $stable(devOwnsSram) |-> hostRdata[4] == !devOwnsSram)
        else $error("completion flag disagrees with ownership");
endmodule // sensor_map_chk

// file: testbench/tb_sensor_command_status_map.sv
/*
 Self-checking bench joining host end and device end on one link.
 Assumes the design package and interface are compiled first.
*/
`timescale 1ns/100ps
`include "sensor_map_defines.svh"
module tb_sensor_command_status_map;
    import sensor_map_pkg::*;
    logic clk = 0, sys_rst = 1, startReq = 0, batteryOn = 0, readReq = 0, sampleValid = 0;
    logic [1:0] rangeSel = 2'h0;
    logic [31:0] readAddr = 32'h0000_0000;
    logic [15:0] sampleData = 16'h0000, rdData, v;
    logic hostBusy, rdValid, acquiring, battEn;
    logic [2:0] rangeEn;
    logic [15:0] mem [0:35];
    int fail_count = 0, n_checks = 0, cycles = 0;
    int slotBase [9] = '{2, 4, 6, 9, 13, 17, 21, 25, 33};
    sensor_map_if link();
    sensor_host_end sensor_host_end_inst (.clk(clk), .sys_rst(sys_rst), .startReq(startReq),
        .batteryOn(batteryOn), .rangeSel(rangeSel), .readAddr(readAddr), .readReq(readReq),
        .busy(hostBusy), .readData_r(rdData), .readValid_r(rdValid), .link(link));
    sensor_device_end sensor_device_end_inst (.clk(clk), .sys_rst(sys_rst), .sampleValid(sampleValid),
        .sampleData(sampleData), .acquiring(acquiring), .batteryEnable(battEn),
        .pressure_range_one_enable(rangeEn[0]), .pressure_range_two_enable(rangeEn[1]),
        .pressure_range_three_enable(rangeEn[2]), .link(link));
    sensor_map_chk sensor_map_chk_inst (.clk(clk), .sys_rst(sys_rst), .hostAddr(link.hostAddr),
        .hostWrite(link.hostWrite), .hostRead(link.hostRead), .hostWdata(link.hostWdata),
        .hostRdata(link.hostRdata), .hostRvalid(link.hostRvalid), .devSramAddr(link.devSramAddr),
        .devSramWe(link.devSramWe), .devSramOe(link.devSramOe), .devOwnsSram(link.devOwnsSram));
    always #2 clk = ~clk;
    // Shadow of the SRAM, filled only from device writes
    always @(posedge clk) begin
        cycles++;
        if (link.devSramWe === 1'b1) mem[6'((link.devSramAddr - `MAP_BASE) >> 1)] <= link.devSramWdata;
        if (cycles == 6000) begin
            fail_count++;
            summarize();
        end
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task readReg(output logic [15:0] r);
        int i;
        @(posedge clk);
        readAddr <= `CMD_ADDR;
        readReq <= 1'b1;
        @(posedge clk);
        readReq <= 1'b0;
        for (i = 0; i < 50 && rdValid !== 1'b1; i++) @(posedge clk) #1;
        check(16'(rdValid), 16'h0001);
        r = {8'h00, rdData[7:0]};
    endtask
    task t_reset();
        readReg(v);
        check(v, 16'h0010);
        check({13'h0, rangeEn}, 16'h0000);
        check(16'(link.devOwnsSram), 16'h0000);
    endtask
    // Every range code, battery toggled on and off along the way
    task t_ranges();
        int r;
        for (r = 0; r < 4; r++) begin
            @(posedge clk);
            batteryOn <= r[0];
            rangeSel <= 2'(r);
            repeat (6) @(posedge clk);
            #1;
            check({13'h0, rangeEn}, r == 0 ? 16'h0000 : 16'h0001 << (r - 1));
            check(16'(battEn), 16'(r[0]));
            readReg(v);
            check(v, 16'h0010 | (r[0] ? 16'h0004 : 16'h0000) | 16'(r));
        end
    endtask
    task t_execute();
        int k, i;
        @(posedge clk);
        batteryOn <= 1'b1;
        rangeSel <= `RANGE_TWO;
        startReq <= 1'b1;
        @(posedge clk);
        startReq <= 1'b0;
        for (i = 0; i < 20 && acquiring !== 1'b1; i++) @(posedge clk) #1;
        check({13'h0, acquiring, link.devOwnsSram, battEn}, 16'h0007);
        for (k = 0; k < 21; k++) begin
            @(posedge clk);
            sampleValid <= 1'b1;
            sampleData <= 16'hA000 + 16'(k);
            @(posedge clk);
            sampleValid <= 1'b0;
        end
        for (i = 0; i < 200 && hostBusy !== 1'b0; i++) @(posedge clk) #1;
        check({14'h0, hostBusy, link.devOwnsSram}, 16'h0000);
        check(16'(acquiring), 16'h0000);
        readReg(v);
        check(v, 16'h0016);
        // All 21 samples must land, the last pressure sample included
        for (k = 0; k < 21; k++) begin
            i = k < 3 ? slotBase[k] : slotBase[(k - 3) / 3 + 3] + (k - 3) % 3;
            check(mem[i], 16'hA000 + 16'(k));
        end
    endtask
    task summarize();
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_ranges();
        t_execute();
        summarize();
    end
endmodule // tb_sensor_command_status_map
